// file: ess_engine.sv
// extended-state save/restore engine with Avalon-MM register slave
// assumes memory answers each request with mem_ack, optionally with mem_fault
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - bounds reg i at bytes 16i..16i+15
// - bounds config low eight, status high
// - bounds components need enable and mask 11b
// - refuse bounds instructions unless fully enabled
// - opmask i at bytes 8i..8i+7
// - upper half i at bytes 32i..32i+31
// - outside 64-bit skip upper halves 8-15
// - high vector i at 64(i-16)
// - outside 64-bit skip high-sixteen section
// - wide-vector components need mask 111b
// - refuse 512-bit instructions unless enabled
// - nine trace MSRs, eight bytes, listed order
// - trace bytes from 72 reserved, saved zero
// - trace state needs enable and supervisor bit
// - save clears trace enable after control
// - fault or exit restores trace enable
// - restore with trace enabled faults first
// - restore faults before trace enable changes
// - key rights in bytes 3:0, bit 9
// - access checks use pre-restore key rights
// - components numbered 3-4, 5-7, 8, 9
// - feature mask bit 0 reads one
module ess_engine
    import ess_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // register slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // save area memory
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [63:0] mem_wdata,
    output logic      [7:0]  mem_be,
    input  wire logic        mem_ack,
    input  wire logic        mem_fault,
    input  wire logic [63:0] mem_rdata,
    input  wire logic        vm_exit,
    // core-side status
    output logic      [31:0] pkey_rights,
    output logic             bounds_instr_refuse,
    output logic             vec512_instr_refuse
);

    typedef enum logic [2:0] {ESS_IDLE, ESS_NEXT, ESS_MEM, ESS_FIN, ESS_ABORT} ess_st_e;

    // ==========================================================
    // state
    logic [63:0] arch_ff [0:255];
    ess_st_e     st_ff;
    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  ctrl_ff;
    logic [9:0]  feat_ff;
    logic [9:0]  sup_ff;
    logic [31:0] base_ff;
    logic [7:0]  idx_ff;
    logic [31:0] lo_ff;
    logic        gp_ff;
    logic        flt_ff;
    logic        ud_ff;
    logic [3:0]  comp_ff;
    logic [7:0]  word_ff;
    logic [9:0]  act_ff;
    logic        rest_ff;
    logic        te_orig_ff;
    logic        te_clr_ff;
    logic        tctl_ld_ff;
    logic [63:0] tctl_hold_ff;
    logic        mreq_ff;
    logic        mwe_ff;
    logic [31:0] maddr_ff;
    logic [63:0] mwdata_ff;
    logic [7:0]  mbe_ff;
    logic [31:0] pkchk_ff;
    logic        bnd_ref_ff;
    logic        vec_ref_ff;

    // ==========================================================
    // bus decode
    wire         bus_take = (avs_read | avs_write) & wait_ff;
    wire         wr_go    = avs_write & ~wait_ff;
    wire         busy     = st_ff != ESS_IDLE;
    wire         cfg_wr   = wr_go & ~busy;
    wire         sel_ctrl = avs_address == ESS_REG_CTRL;
    wire         sel_feat = avs_address == ESS_REG_FEAT;
    wire         sel_sup  = avs_address == ESS_REG_SUP;
    wire         sel_cmd  = avs_address == ESS_REG_CMD;
    wire         sel_stat = avs_address == ESS_REG_STAT;
    wire         sel_base = avs_address == ESS_REG_BASE;
    wire         sel_idx  = avs_address == ESS_REG_IDX;
    wire         sel_lo   = avs_address == ESS_REG_LO;
    wire         sel_hi   = avs_address == ESS_REG_HI;
    wire  [63:0] win_word = arch_ff[idx_ff];
    wire  [63:0] tctl_cur = arch_ff[ESS_TCTL_IDX];
    wire         te       = tctl_cur[ESS_TE_BIT];
    wire  [31:0] stat_w   = {27'h0, te, ud_ff, flt_ff, gp_ff, busy};
    // unmapped offsets read zero and swallow writes
    wire  [31:0] rd_mux   = sel_ctrl ? {30'h0, ctrl_ff} :
                            sel_feat ? {22'h0, feat_ff} :
                            sel_sup  ? {22'h0, sup_ff} :
                            sel_stat ? stat_w :
                            sel_base ? base_ff :
                            sel_idx  ? {24'h0, idx_ff} :
                            sel_lo   ? win_word[31:0] :
                            sel_hi   ? win_word[63:32] : 32'h0;

    // ==========================================================
    // enable gating
    wire         osx      = ctrl_ff[ESS_CTRL_OSX];
    wire         mode64   = ctrl_ff[ESS_CTRL_M64];
    wire         bnd_ok   = osx & (&feat_ff[4:3]);
    wire         vec_ok   = osx & (&feat_ff[7:5]);
    wire         cmd_go   = cfg_wr & sel_cmd;
    wire         cmd_rest = avs_writedata[ESS_CMD_REST];
    wire  [9:0]  nact;
    assign nact[2:0] = 3'h0;
    assign nact[4:3] = {2{bnd_ok}} & avs_writedata[4:3];
    assign nact[7:5] = {3{vec_ok}} & avs_writedata[7:5];
    assign nact[8]   = osx & sup_ff[8] & avs_writedata[ESS_CMD_SUPER] & avs_writedata[8];
    assign nact[9]   = osx & feat_ff[9] & avs_writedata[9];
    wire         start_ud = ~osx;
    wire         start_gp = osx & cmd_rest & nact[8] & te;

    // ==========================================================
    // walk through sections
    wire  [2:0]  ci       = comp_ff[2:0] - 3'h3;
    wire         c_end    = comp_ff > ESS_C_PKEY;
    wire  [7:0]  c_words  = ESS_MEM_WORDS[ci];
    wire  [7:0]  c_idx    = ESS_ARCH_BASE[ci] + word_ff;
    wire         is_pkey  = comp_ff == ESS_C_PKEY;
    wire         is_tctl  = (comp_ff == ESS_C_TRACE) && (word_ff == 8'h00);
    wire         resv     = (comp_ff == ESS_C_TRACE) && (word_ff >= ESS_TRACE_MSRS);
    wire         up_hi    = (comp_ff == ESS_C_UPPER) && (word_ff >= ESS_UPPER_LO);
    wire         skip     = (~mode64 & (up_hi | (comp_ff == ESS_C_HI16))) | (rest_ff & resv);
    wire         c_skip   = c_end ? 1'b0 : (~act_ff[comp_ff] | (word_ff >= c_words));
    wire  [63:0] src      = arch_ff[c_idx];
    wire  [63:0] sv_data  = resv ? 64'h0 : is_pkey ? {32'h0, src[31:0]} : src;
    wire  [31:0] c_addr   = base_ff + ESS_AREA_OFF[ci] + {21'h0, word_ff, 3'h0};
    wire         acked    = (st_ff == ESS_MEM) & mem_ack & ~mem_fault & ~vm_exit;
    wire         abort_ev = (st_ff == ESS_MEM) & (vm_exit | (mem_ack & mem_fault));

    // ==========================================================
    // state array write port
    wire         win_wr   = cfg_wr & sel_hi & (idx_ff < ESS_ARCH_WORDS);
    wire         te_clear = acked & ~rest_ff & is_tctl;
    wire         te_back  = (st_ff == ESS_ABORT) & ~rest_ff & te_clr_ff;
    wire         ld_wr    = acked & rest_ff & ~is_tctl;
    wire         tc_fin   = (st_ff == ESS_FIN) & tctl_ld_ff;
    wire         aw_en    = win_wr | te_clear | te_back | ld_wr | tc_fin;
    wire  [63:0] te_gone  = tctl_cur & ~ESS_TE_MASK;
    wire  [63:0] ld_data  = is_pkey ? {32'h0, mem_rdata[31:0]} : mem_rdata;
    wire  [7:0]  aw_idx   = win_wr ? idx_ff :
                            (te_clear | te_back | tc_fin) ? ESS_TCTL_IDX : c_idx;
    wire  [63:0] aw_data  = win_wr   ? {avs_writedata, lo_ff} :
                            te_clear ? te_gone :
                            te_back  ? (te_gone | (te_orig_ff ? ESS_TE_MASK : 64'h0)) :
                            tc_fin   ? tctl_hold_ff : ld_data;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 256; i++)
            begin
                arch_ff[i] <= 64'h0;
            end
        end
        else if (ce && aw_en)
        begin
            arch_ff[aw_idx] <= aw_data;
        end
    end

    // ==========================================================
    // register slave, one wait cycle per access
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0;
        end
        else if (ce)
        begin
            wait_ff <= ~bus_take;
            if (bus_take && avs_read)
            begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // config is frozen while a command runs so gating cannot shift mid-walk
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_ff <= 2'h0;
            feat_ff <= ESS_FEAT_RST;
            sup_ff  <= 10'h000;
            base_ff <= 32'h0;
            idx_ff  <= 8'h00;
            lo_ff   <= 32'h0;
        end
        else if (ce && cfg_wr)
        begin
            if (sel_ctrl)
            begin
                ctrl_ff <= avs_writedata[1:0];
            end
            if (sel_feat)
            begin
                feat_ff <= avs_writedata[9:0] | ESS_FEAT_RST;
            end
            if (sel_sup)
            begin
                sup_ff <= avs_writedata[9:0];
            end
            if (sel_base)
            begin
                base_ff <= {avs_writedata[31:3], 3'h0};
            end
            if (sel_idx)
            begin
                idx_ff <= avs_writedata[7:0];
            end
            if (sel_lo)
            begin
                lo_ff <= avs_writedata;
            end
        end
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff        <= ESS_IDLE;
            comp_ff      <= ESS_C_BOUNDS_REG_COMPONENT;
            word_ff      <= 8'h00;
            act_ff       <= 10'h000;
            rest_ff      <= 1'b0;
            te_orig_ff   <= 1'b0;
            te_clr_ff    <= 1'b0;
            tctl_ld_ff   <= 1'b0;
            tctl_hold_ff <= 64'h0;
            gp_ff        <= 1'b0;
            flt_ff       <= 1'b0;
            ud_ff        <= 1'b0;
            mreq_ff      <= 1'b0;
            mwe_ff       <= 1'b0;
            maddr_ff     <= 32'h0;
            mwdata_ff    <= 64'h0;
            mbe_ff       <= 8'h00;
        end
        else if (ce)
        begin
            case (st_ff)
                ESS_IDLE:
                begin
                    if (cmd_go)
                    begin
                        ud_ff      <= start_ud;
                        gp_ff      <= start_gp;
                        flt_ff     <= 1'b0;
                        comp_ff    <= ESS_C_BOUNDS_REG_COMPONENT;
                        word_ff    <= 8'h00;
                        act_ff     <= nact;
                        rest_ff    <= cmd_rest;
                        te_orig_ff <= te;
                        te_clr_ff  <= 1'b0;
                        tctl_ld_ff <= 1'b0;
                        if (!start_ud && !start_gp)
                        begin
                            st_ff <= ESS_NEXT;
                        end
                    end
                end
                ESS_NEXT:
                begin
                    if (c_end)
                    begin
                        st_ff <= ESS_FIN;
                    end
                    else if (c_skip)
                    begin
                        comp_ff <= comp_ff + 4'h1;
                        word_ff <= 8'h00;
                    end
                    else if (skip)
                    begin
                        word_ff <= word_ff + 8'h01;
                    end
                    else
                    begin
                        mreq_ff   <= 1'b1;
                        mwe_ff    <= ~rest_ff;
                        maddr_ff  <= c_addr;
                        mwdata_ff <= sv_data;
                        mbe_ff    <= is_pkey ? ESS_PKEY_BE : ESS_FULL_BE;
                        st_ff     <= ESS_MEM;
                    end
                end
                ESS_MEM:
                begin
                    if (abort_ev)
                    begin
                        mreq_ff <= 1'b0;
                        st_ff   <= ESS_ABORT;
                    end
                    else if (acked)
                    begin
                        mreq_ff <= 1'b0;
                        word_ff <= word_ff + 8'h01;
                        st_ff   <= ESS_NEXT;
                        if (is_tctl && rest_ff)
                        begin
                            tctl_ld_ff   <= 1'b1;
                            tctl_hold_ff <= mem_rdata;
                        end
                        if (te_clear)
                        begin
                            te_clr_ff <= 1'b1;
                        end
                    end
                end
                ESS_FIN:
                begin
                    st_ff <= ESS_IDLE;
                end
                default:
                begin
                    flt_ff <= 1'b1;
                    st_ff  <= ESS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // core-side status
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pkchk_ff   <= 32'h0;
            bnd_ref_ff <= 1'b1;
            vec_ref_ff <= 1'b1;
        end
        else if (ce)
        begin
            // snapshot held through a command; loads land only after it ends
            if (!busy)
            begin
                pkchk_ff <= arch_ff[ESS_PKEY_IDX][31:0];
            end
            bnd_ref_ff <= ~bnd_ok;
            vec_ref_ff <= ~vec_ok;
        end
    end

    assign avs_readdata        = rdata_ff;
    assign avs_waitrequest     = wait_ff;
    assign mem_req             = mreq_ff;
    assign mem_we              = mwe_ff;
    assign mem_addr            = maddr_ff;
    assign mem_wdata           = mwdata_ff;
    assign mem_be              = mbe_ff;
    assign pkey_rights         = pkchk_ff;
    assign bounds_instr_refuse = bnd_ref_ff;
    assign vec512_instr_refuse = vec_ref_ff;

    // ==========================================================
    // checks
    default clocking ess_cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_bnd_gate: assert property (mreq_ff && (comp_ff == ESS_C_BOUNDS_REG_COMPONENT || comp_ff == ESS_C_BOUNDS_CSR_COMPONENT)
        |-> osx && (&feat_ff[4:3])) else $error("bounds access while not enabled");
    a_vec_gate: assert property (mreq_ff && comp_ff >= ESS_C_OPMASK && comp_ff <= ESS_C_HI16
        |-> osx && (&feat_ff[7:5])) else $error("vector access while not enabled");
    a_trace_gate: assert property (mreq_ff && comp_ff == ESS_C_TRACE |-> osx && sup_ff[8])
        else $error("trace access while not enabled");
    a_pkey_gate: assert property (mreq_ff && is_pkey |-> feat_ff[9] && mbe_ff == ESS_PKEY_BE)
        else $error("key rights access wrong");
    a_upper_skip: assert property (mreq_ff && !mode64 && comp_ff == ESS_C_UPPER
        |-> word_ff < ESS_UPPER_LO) else $error("upper halves 8-15 touched");
    a_hi16_skip: assert property (mreq_ff && !mode64 |-> comp_ff != ESS_C_HI16)
        else $error("high-sixteen section touched");
    a_resv_zero: assert property (mreq_ff && mwe_ff && resv |-> mwdata_ff == 64'h0)
        else $error("reserved trace bytes not zero");
    a_te_clear: assert property (ce && te_clear |=> !tctl_cur[ESS_TE_BIT] && st_ff == ESS_NEXT)
        else $error("trace enable not cleared");
    a_te_back: assert property (ce && te_back |=> tctl_cur[ESS_TE_BIT] == $past(te_orig_ff))
        else $error("trace enable not returned");
    a_gp_first: assert property (ce && cmd_go && start_gp
        |=> gp_ff && st_ff == ESS_IDLE && $stable(tctl_cur)) else $error("restore fault late");
    a_te_hold: assert property (ce && rest_ff && (st_ff == ESS_MEM || st_ff == ESS_ABORT)
        |=> $stable(tctl_cur[ESS_TE_BIT])) else $error("trace enable moved early");
    a_pkey_snap: assert property (busy |=> $stable(pkchk_ff))
        else $error("key rights changed in command");
    a_feat_one: assert property (feat_ff[0])
        else $error("feature bit 0 low");
    a_bnd_refuse: assert property (ce |=> bnd_ref_ff == $past(!bnd_ok))
        else $error("bounds refusal wrong");

endmodule

`default_nettype wire

// file: ess_engine_test.sv
// self-checking bench for the state save engine
// assumes ess_mem_model holds the save area at B
`timescale 1ns/1ns
`default_nettype none
module ess_engine_test
    import ess_pkg::*;
;
    localparam logic [31:0] B = 32'h0000_1000;
    logic        clk;
    logic        rst_b;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [63:0] mem_wdata;
    logic [7:0]  mem_be;
    logic        mem_ack;
    logic        mem_fault;
    logic [63:0] mem_rdata;
    logic [31:0] pkey_rights;
    logic        b_ref;
    logic        v_ref;
    logic [3:0]  lat;
    logic [31:0] fault_addr;
    logic        vm_exit;
    logic [31:0] q;
    int          errors;
    int          n_tests;
    int          cyc;
    // ==========================================================
    // design and memory
    ess_engine uut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
        .mem_ack(mem_ack), .mem_fault(mem_fault), .mem_rdata(mem_rdata), .vm_exit(vm_exit),
        .pkey_rights(pkey_rights), .bounds_instr_refuse(b_ref), .vec512_instr_refuse(v_ref));
    ess_mem_model m (.clk(clk), .rst_b(rst_b), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
        .mem_fault(mem_fault), .mem_rdata(mem_rdata), .lat(lat), .fault_addr(fault_addr));
    always #2 clk = ~clk;
    // ==========================================================
    // helpers
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic word(input logic [7:0] i, input logic [63:0] v);
        bus(1'b1, ESS_REG_IDX, 32'(i));
        bus(1'b1, ESS_REG_LO, v[31:0]);
        bus(1'b1, ESS_REG_HI, v[63:32]);
    endtask
    task automatic rdw(input logic [7:0] i);
        bus(1'b1, ESS_REG_IDX, 32'(i));
        bus(1'b0, ESS_REG_LO, 32'h0);
    endtask
    // leaves the final status word in q
    task automatic run(input logic [31:0] c);
        bus(1'b1, ESS_REG_CMD, c);
        do bus(1'b0, ESS_REG_STAT, 32'h0); while (q[0] !== 1'b0);
    endtask
    function automatic logic [63:0] pk(input logic [31:0] a);
        return m.mem.exists(a) ? m.mem[a] : 64'h0;
    endfunction
    task automatic final_report;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            final_report;
        end
    end
    // ==========================================================
    // scenarios
    task automatic t_gate;
        chk(64'(b_ref), 64'h1);
        bus(1'b1, ESS_REG_FEAT, 32'h0);
        bus(1'b0, ESS_REG_FEAT, 32'h0);
        chk(64'(q), 64'h001);
        run(32'h0F8);
        chk(64'(q[3]), 64'h1);
        bus(1'b1, ESS_REG_CTRL, 32'h3);
        bus(1'b1, ESS_REG_FEAT, 32'h0E8);
        bus(1'b0, ESS_REG_FEAT, 32'h0);
        chk(64'(b_ref), 64'h1);
        chk(64'(v_ref), 64'h0);
        bus(1'b1, ESS_REG_FEAT, 32'h2F8);
        bus(1'b0, ESS_REG_FEAT, 32'h0);
        chk(64'(b_ref), 64'h0);
        chk(64'(v_ref), 64'h0);
    endtask
    task automatic t_layout;
        bus(1'b1, ESS_REG_BASE, B);
        word(8'd2, 64'hA1);
        word(8'd9, 64'hB2);
        word(8'd11, 64'hC3);
        word(8'd54, 64'hD4);
        word(8'd90, 64'hE5);
        run(32'h0F8);
        chk(pk(B + ESS_AREA_OFF[0] + 32'd16), 64'hA1);
        chk(pk(B + ESS_AREA_OFF[1] + 32'd8), 64'hB2);
        chk(pk(B + ESS_AREA_OFF[2] + 32'd8), 64'hC3);
        chk(pk(B + ESS_AREA_OFF[3] + 32'd288), 64'hD4);
        chk(pk(B + ESS_AREA_OFF[4] + 32'd64), 64'hE5);
        lat <= 4'h2;
        bus(1'b1, ESS_REG_CTRL, 32'h1);
        word(8'd54, 64'h77);
        word(8'd90, 64'h88);
        run(32'h0C0);
        chk(pk(B + ESS_AREA_OFF[3] + 32'd288), 64'hD4);
        chk(pk(B + ESS_AREA_OFF[4] + 32'd64), 64'hE5);
        run(32'h100C0);
        rdw(8'd54);
        chk(64'(q), 64'h77);
        rdw(8'd90);
        chk(64'(q), 64'h88);
    endtask
    task automatic t_pkey;
        word(8'd219, 64'hCAFE_1234);
        run(32'h200);
        chk(64'(pk(B + ESS_AREA_OFF[6]) & 64'hFFFF_FFFF), 64'hCAFE_1234);
        m.mem[B + ESS_AREA_OFF[6]] = 64'h5A5A_0F0F;
        bus(1'b1, ESS_REG_CMD, 32'h10200);
        // look after the load has landed but before the engine goes idle
        do @(posedge clk); while (!(mem_req && mem_ack));
        repeat (2) @(posedge clk);
        chk(64'(pkey_rights), 64'hCAFE_1234);
        run(32'h0);
        chk(64'(pkey_rights), 64'h5A5A_0F0F);
    endtask
    task automatic t_trace;
        bus(1'b1, ESS_REG_SUP, 32'h100);
        word(8'd210, 64'h5);
        word(8'd211, 64'h11);
        m.mem[B + 32'h948] = 64'hFFFF;
        run(32'h20100);
        chk(64'(q[4]), 64'h0);
        chk(pk(B + 32'h900), 64'h5);
        chk(pk(B + 32'h908), 64'h11);
        chk(pk(B + 32'h948), 64'h0);
        word(8'd210, 64'h5);
        m.mem[B + 32'h908] = 64'h22;
        run(32'h30100);
        chk(64'(q[1]), 64'h1);
        rdw(8'd211);
        chk(64'(q), 64'h11);
        fault_addr <= B + 32'h908;
        run(32'h20100);
        chk(64'(q[4:2]), 64'h5);
        word(8'd210, 64'h4);
        m.mem[B + 32'h900] = 64'h5;
        run(32'h30100);
        chk(64'(q[4:2]), 64'h1);
        fault_addr <= 32'hFFFF_FFFF;
        word(8'd210, 64'h5);
        bus(1'b1, ESS_REG_CMD, 32'h20100);
        // exit while the second trace word is outstanding
        do @(posedge clk); while (!(mem_req && mem_addr == B + 32'h908));
        vm_exit <= 1'b1;
        @(posedge clk);
        vm_exit <= 1'b0;
        do bus(1'b0, ESS_REG_STAT, 32'h0); while (q[0] !== 1'b0);
        chk(64'(q[4:2]), 64'h5);
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        lat = 4'h0;
        vm_exit = 1'b0;
        fault_addr = 32'hFFFF_FFFF;
        errors = 0;
        n_tests = 0;
        cyc = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_gate;
        t_layout;
        t_pkey;
        t_trace;
        final_report;
    end
endmodule
`default_nettype wire

// file: ess_mem_model.sv
// save area memory standing beside the state engine
// assumes one request at a time; answers after lat extra cycles
`timescale 1ns/1ns
`default_nettype none
module ess_mem_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // request
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [63:0] mem_wdata,
    input  wire logic [7:0]  mem_be,
    // answer
    output logic             mem_ack,
    output logic             mem_fault,
    output logic      [63:0] mem_rdata,
    // knobs
    input  wire logic [3:0]  lat,
    input  wire logic [31:0] fault_addr
);
    logic [63:0] mem [int];
    logic [63:0] w;
    logic [3:0]  cnt;
    // ==========================================================
    // answer
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt <= 4'h0;
            mem_ack <= 1'b0;
            mem_fault <= 1'b0;
            mem_rdata <= 64'h0;
        end
        else if (mem_req && !mem_ack && cnt >= lat)
        begin
            cnt <= 4'h0;
            mem_ack <= 1'b1;
            mem_fault <= (mem_addr == fault_addr);
            w = mem.exists(mem_addr) ? mem[mem_addr] : 64'h0;
            for (int b = 0; b < 8; b++)
                if (mem_we && mem_be[b])
                    w[8*b +: 8] = mem_wdata[8*b +: 8];
            if (mem_we && mem_addr != fault_addr)
                mem[mem_addr] = w;
            mem_rdata <= mem_we ? ~mem_rdata : w;
        end
        else
        begin
            cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
            mem_ack <= 1'b0;
            mem_fault <= 1'b0;
            // no stale data between answers
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

// file: ess_pkg.sv
// constants for the extended-state save/restore engine
// assumes a 64-bit memory word port and a 32-bit register slave
package ess_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0]  ESS_REG_CTRL  = 8'h00;
    localparam logic [7:0]  ESS_REG_FEAT  = 8'h04;
    localparam logic [7:0]  ESS_REG_SUP   = 8'h08;
    localparam logic [7:0]  ESS_REG_CMD   = 8'h0C;
    localparam logic [7:0]  ESS_REG_STAT  = 8'h10;
    localparam logic [7:0]  ESS_REG_BASE  = 8'h14;
    localparam logic [7:0]  ESS_REG_IDX   = 8'h18;
    localparam logic [7:0]  ESS_REG_LO    = 8'h1C;
    localparam logic [7:0]  ESS_REG_HI    = 8'h20;

    // ==========================================================
    // field positions and reset values
    localparam int          ESS_CTRL_OSX  = 0;
    localparam int          ESS_CTRL_M64  = 1;
    localparam int          ESS_CMD_REST  = 16;
    localparam int          ESS_CMD_SUPER = 17;
    localparam int          ESS_TE_BIT    = 0;
    localparam logic [63:0] ESS_TE_MASK   = 64'h0000_0000_0000_0001;
    localparam logic [9:0]  ESS_FEAT_RST  = 10'h001;
    localparam logic [7:0]  ESS_PKEY_BE   = 8'h0F;
    localparam logic [7:0]  ESS_FULL_BE   = 8'hFF;

    // ==========================================================
    // component numbers
    localparam logic [3:0]  ESS_C_BOUNDS_REG_COMPONENT = 4'h3;
    localparam logic [3:0]  ESS_C_BOUNDS_CSR_COMPONENT  = 4'h4;
    localparam logic [3:0]  ESS_C_OPMASK  = 4'h5;
    localparam logic [3:0]  ESS_C_UPPER   = 4'h6;
    localparam logic [3:0]  ESS_C_HI16    = 4'h7;
    localparam logic [3:0]  ESS_C_TRACE   = 4'h8;
    localparam logic [3:0]  ESS_C_PKEY    = 4'h9;

    // ==========================================================
    // section shapes in 64-bit words and area offsets in bytes, indexed by component minus 3
    localparam logic [7:0]  ESS_TRACE_MSRS = 8'h09;
    localparam logic [7:0]  ESS_UPPER_LO   = 8'h20;
    localparam logic [7:0]  ESS_ARCH_WORDS = 8'hDC;
    localparam logic [7:0]  ESS_TCTL_IDX   = 8'hD2;
    localparam logic [7:0]  ESS_PKEY_IDX   = 8'hDB;
    localparam logic [7:0]  ESS_ARCH_BASE [0:6] = '{8'h00, 8'h08, 8'h0A, 8'h12, 8'h52, 8'hD2, 8'hDB};
    localparam logic [7:0]  ESS_MEM_WORDS [0:6] = '{8'h08, 8'h02, 8'h08, 8'h40, 8'h80, 8'h10, 8'h01};
    localparam logic [31:0] ESS_AREA_OFF  [0:6] = '{32'h0000_0240, 32'h0000_0280, 32'h0000_02C0,
                                                    32'h0000_0300, 32'h0000_0500, 32'h0000_0900,
                                                    32'h0000_0980};

endpackage
